// *** mpf_map.vh ***
`ifndef MPF_MAP_VH
`define MPF_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MPF_OFS_MGMT_CTRL 9'h000
`define MPF_OFS_MGMT_DATA 9'h004
`define MPF_OFS_RX_CFG 9'h008
`define MPF_OFS_FILT_STAT 9'h00c
`define MPF_OFS_STA_LO 9'h010
`define MPF_OFS_STA_HI 9'h014
// Exact table: 0x100 + 8*entry (+0 low word, +4 high word)
`define MPF_EXACT_SEL 2'b10
// Hash table: 0x180 + 4*word, word 0 holds table bits 31:0
`define MPF_HASH_SEL 3'b110
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MPF_CTRL_PHY_HI 15
`define MPF_CTRL_PHY_LO 11
`define MPF_CTRL_REG_HI 10
`define MPF_CTRL_REG_LO 6
`define MPF_CTRL_WRITE 1
`define MPF_CTRL_BUSY 0
`define MPF_HI_VALID 31
`define MPF_CFG_RX_EN 0
`define MPF_CFG_INVERSE 1
`define MPF_CFG_MODE_HI 3
`define MPF_CFG_MODE_LO 2
// ----------------------------------------
// Reset values and filter modes
// ----------------------------------------
`define MPF_RST_WORD 32'h0000_0000
`define MPF_MODE_EXACT 2'h0
`define MPF_MODE_HASH_MC 2'h1
`define MPF_MODE_HASH_ALL 2'h2
`define MPF_MODE_PROMISC 2'h3
`define MPF_CRC_POLY 32'h04c1_1db7
`define MPF_CRC_INIT 32'hffff_ffff
// ----------------------------------------
// Timing
// ----------------------------------------
`define MPF_CLK_PERIOD_NS 100
`define MPF_MDC_PERIOD_NS 400
`define MPF_MDC_HALF_CYC ((`MPF_MDC_PERIOD_NS + 2 * `MPF_CLK_PERIOD_NS - 1) / (2 * `MPF_CLK_PERIOD_NS))
`define MPF_FRAME_BITS 64
`define MPF_LAST_ADDR_BIT 45
`define MPF_FIRST_DATA_BIT 48
`endif

// *** mpf_mac_mgmt_filter.v ***
// Behaviour
// - Control bits 15:11 select the target PHY.
// - Control bits 10:6 select the register inside that PHY.
// - Control bit 1 set means write from data register, clear means read.
// - Busy reads one during an access; control and data writes then dropped.
// - Both management registers reset to zero.
// - Data bits 15:0 take the read word and supply the write word.
// - 48-bit addresses filtered by exact or hash table, one at a time.
// - Exact table has sixteen full 48-bit entries checked on every frame.
// - Exact mode drops misses, or drops hits when inverse filtering set.
// - In exact mode, with no valid exact entry every frame is accepted.
// - Entry: valid at bit 63, reserved 62:48, address 47:0.
// - Hash filter keeps 512 bucket bits and one station address.
// - Multicast index is CRC top nine bits; set bit accepts.
// - First hash mode hashes multicast, compares physical to station address.
// - Second hash mode hashes every destination address.
`timescale 1ns/1ns
`default_nettype none
`include "mpf_map.vh"
module mpf_mac_mgmt_filter #(
   parameter ENTRIES = 16,
   parameter MDC_HALF = `MPF_MDC_HALF_CYC
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire rst_in,
   // Register port
   input wire [8:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   // Management link
   output reg mdc_out,
   input wire mdio_in,
   output wire mdio_out,
   output reg mdio_oe_n_out,
   // Address check from receiver
   input wire chk_valid_in,
   input wire [47:0] chk_addr_in,
   output reg chk_done_out,
   output reg chk_accept_out
);
   // ----------------------------------------
   // Management registers
   // ----------------------------------------
   reg [4:0] phy_select_field;
   reg [4:0] reg_index;
   reg write_dir;
   reg busy;
   reg [15:0] mgmt_data;
   reg [2:0] mdio_sync;
   reg [7:0] div_cnt;
   reg [5:0] bit_idx;
   reg [63:0] frame_sr;
   wire ctrl_hit = reg_addr_in == `MPF_OFS_MGMT_CTRL;
   wire data_hit = reg_addr_in == `MPF_OFS_MGMT_DATA;
   wire start = reg_wr_in && ctrl_hit && !busy;
   wire tick = busy && (div_cnt == MDC_HALF - 1);
   wire last_bit = bit_idx == `MPF_FRAME_BITS - 1;
   assign mdio_out = frame_sr[63];

   // ----------------------------------------
   // Read data synchroniser
   // ----------------------------------------
   // Three flops: the pin is seen about three clocks late, still inside the bit
   // Each stage is read only by the next, so a metastable stage never fans out
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         mdio_sync <= 3'h0;
      end else begin
         mdio_sync <= {mdio_sync[1:0], mdio_in};
      end
   end

   // ----------------------------------------
   // Frame engine
   // ----------------------------------------
   // One frame at a time: a second start is refused until busy clears
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         phy_select_field <= 5'h00;
         reg_index <= 5'h00;
         write_dir <= 1'b0;
         busy <= 1'b0;
         mgmt_data <= 16'h0000;
         div_cnt <= 8'h00;
         bit_idx <= 6'h00;
         frame_sr <= 64'h0;
         mdc_out <= 1'b0;
         mdio_oe_n_out <= 1'b1;
      end else if (start) begin
         phy_select_field <= reg_wdata_in[`MPF_CTRL_PHY_HI:`MPF_CTRL_PHY_LO];
         reg_index <= reg_wdata_in[`MPF_CTRL_REG_HI:`MPF_CTRL_REG_LO];
         write_dir <= reg_wdata_in[`MPF_CTRL_WRITE];
         busy <= 1'b1;
         div_cnt <= 8'h00;
         bit_idx <= 6'h00;
         mdc_out <= 1'b0;
         mdio_oe_n_out <= 1'b0;
         // Preamble, start, opcode, addresses, turnaround, data
         frame_sr <= {32'hffff_ffff, 2'b01,
            reg_wdata_in[`MPF_CTRL_WRITE] ? 2'b01 : 2'b10,
            reg_wdata_in[`MPF_CTRL_PHY_HI:`MPF_CTRL_PHY_LO],
            reg_wdata_in[`MPF_CTRL_REG_HI:`MPF_CTRL_REG_LO],
            reg_wdata_in[`MPF_CTRL_WRITE] ? 2'b10 : 2'b11,
            reg_wdata_in[`MPF_CTRL_WRITE] ? mgmt_data : 16'hffff};
      end else if (busy) begin
         div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
         if (tick && !mdc_out) begin
            mdc_out <= 1'b1;
         end else if (tick) begin
            // Falling edge: sample read bit late in the high phase, then advance
            mdc_out <= 1'b0;
            if (!write_dir && bit_idx >= `MPF_FIRST_DATA_BIT) begin
               mgmt_data <= {mgmt_data[14:0], mdio_sync[2]};
            end
            if (last_bit) begin
               busy <= 1'b0;
               mdio_oe_n_out <= 1'b1;
            end else begin
               bit_idx <= bit_idx + 6'h01;
               frame_sr <= {frame_sr[62:0], 1'b1};
               if (!write_dir && bit_idx == `MPF_LAST_ADDR_BIT) begin
                  mdio_oe_n_out <= 1'b1;
               end
            end
         end
      end else if (reg_wr_in && data_hit) begin
         mgmt_data <= reg_wdata_in[15:0];
      end
   end

   // ----------------------------------------
   // Filter configuration and tables
   // ----------------------------------------
   reg [3:0] rx_frame_config_register;
   reg [47:0] station_address_field;
   reg [31:0] hash_word [0:15];
   reg [47:0] entry_addr [0:ENTRIES-1];
   reg [ENTRIES-1:0] entry_valid_flag;
   reg [2:0] filt_stat;
   wire [ENTRIES-1:0] entry_hit;
   wire exact_sel = reg_addr_in[8:7] == `MPF_EXACT_SEL;
   wire hash_sel = reg_addr_in[8:6] == `MPF_HASH_SEL;
   wire [3:0] ent_no = reg_addr_in[6:3];

   // ----------------------------------------
   // Exact-match table
   // ----------------------------------------
   // Table writes are not blocked while receiving; software keeps reception off
   genvar g;
   generate
      for (g = 0; g < ENTRIES; g = g + 1) begin : g_entry
         always @(posedge clk_sys_in) begin
            if (rst_in) begin
               entry_valid_flag[g] <= 1'b0;
               entry_addr[g] <= 48'h0;
            end else if (reg_wr_in && exact_sel && ent_no == g) begin
               if (reg_addr_in[2]) begin
                  entry_valid_flag[g] <= reg_wdata_in[`MPF_HI_VALID];
                  entry_addr[g][47:32] <= reg_wdata_in[15:0];
               end else begin
                  entry_addr[g][31:0] <= reg_wdata_in;
               end
            end
         end
         assign entry_hit[g] = entry_valid_flag[g] && entry_addr[g] == chk_addr_in;
      end
   endgenerate

   // ----------------------------------------
   // Hash table and station address
   // ----------------------------------------
   integer i;
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         rx_frame_config_register <= 4'h0;
         station_address_field <= 48'h0;
         for (i = 0; i < 16; i = i + 1) begin
            hash_word[i] <= 32'h0;
         end
      end else if (reg_wr_in) begin
         if (reg_addr_in == `MPF_OFS_RX_CFG) begin
            rx_frame_config_register <= reg_wdata_in[3:0];
         end
         if (reg_addr_in == `MPF_OFS_STA_LO) begin
            station_address_field[31:0] <= reg_wdata_in;
         end
         if (reg_addr_in == `MPF_OFS_STA_HI) begin
            station_address_field[47:32] <= reg_wdata_in[15:0];
         end
         if (hash_sel) begin
            hash_word[reg_addr_in[5:2]] <= reg_wdata_in;
         end
      end
   end

   // ----------------------------------------
   // Address decision
   // ----------------------------------------
   // Bits 47:40 are the first byte on the wire, each byte sent LSB first
   function [8:0] hash_index;
      input [47:0] a;
      reg [31:0] c;
      integer b;
      integer k;
      begin
         c = `MPF_CRC_INIT;
         for (b = 0; b < 6; b = b + 1) begin
            for (k = 0; k < 8; k = k + 1) begin
               if (c[31] ^ a[47 - 8 * b - 7 + k]) begin
                  c = {c[30:0], 1'b0} ^ `MPF_CRC_POLY;
               end else begin
                  c = {c[30:0], 1'b0};
               end
            end
         end
         hash_index = c[31:23];
      end
   endfunction

   wire [8:0] hidx = hash_index(chk_addr_in);
   wire [31:0] hword = hash_word[hidx[8:5]];
   wire hash_bit = hword[hidx[4:0]];
   wire multicast = chk_addr_in[40];
   wire any_hit = |entry_hit;
   wire inverse = rx_frame_config_register[`MPF_CFG_INVERSE];
   wire [1:0] mode = rx_frame_config_register[`MPF_CFG_MODE_HI:`MPF_CFG_MODE_LO];
   reg next_accept;

   always @* begin
      case (mode)
         `MPF_MODE_EXACT: begin
            if (entry_valid_flag == {ENTRIES{1'b0}}) begin
               next_accept = 1'b1;
            end else begin
               next_accept = inverse ? !any_hit : any_hit;
            end
         end
         `MPF_MODE_HASH_MC: begin
            next_accept = multicast ? hash_bit : chk_addr_in == station_address_field;
         end
         `MPF_MODE_HASH_ALL: begin
            next_accept = hash_bit;
         end
         default: begin
            next_accept = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // Check result
   // ----------------------------------------
   // Accept holds between checks so the receiver may pick it up late
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         chk_done_out <= 1'b0;
         chk_accept_out <= 1'b0;
         filt_stat <= 3'h0;
      end else begin
         chk_done_out <= chk_valid_in && rx_frame_config_register[`MPF_CFG_RX_EN];
         if (chk_valid_in && rx_frame_config_register[`MPF_CFG_RX_EN]) begin
            chk_accept_out <= next_accept;
            filt_stat <= {hash_bit, any_hit, next_accept};
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always @(posedge clk_sys_in) begin
      if (rst_in) begin
         reg_rdata_out <= `MPF_RST_WORD;
      end else if (reg_rd_in) begin
         if (ctrl_hit) begin
            reg_rdata_out <= {16'h0, phy_select_field, reg_index, 4'h0,
               write_dir, busy};
         end else if (data_hit) begin
            reg_rdata_out <= {16'h0, mgmt_data};
         end else if (reg_addr_in == `MPF_OFS_RX_CFG) begin
            reg_rdata_out <= {28'h0, rx_frame_config_register};
         end else if (reg_addr_in == `MPF_OFS_FILT_STAT) begin
            reg_rdata_out <= {29'h0, filt_stat};
         end else if (reg_addr_in == `MPF_OFS_STA_LO) begin
            reg_rdata_out <= station_address_field[31:0];
         end else if (reg_addr_in == `MPF_OFS_STA_HI) begin
            reg_rdata_out <= {16'h0, station_address_field[47:32]};
         end else if (exact_sel && reg_addr_in[2]) begin
            reg_rdata_out <= {entry_valid_flag[ent_no], 15'h0, entry_addr[ent_no][47:32]};
         end else if (exact_sel) begin
            reg_rdata_out <= entry_addr[ent_no][31:0];
         end else if (hash_sel) begin
            reg_rdata_out <= hash_word[reg_addr_in[5:2]];
         end else begin
            reg_rdata_out <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire

// *** mpf_phy_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mpf_phy_model (
   // Link side
   input wire logic mdc_in,
   input wire logic rst_in,
   input wire logic line_in,
   output logic drv_out,
   // Bench side
   input wire logic [15:0] rd_word_in,
   output logic [63:0] frame_out
);
   logic [5:0] cnt;
   logic [63:0] sr;
   logic rd_op;
   initial drv_out = 1'b0;
   // ----
   // Bits are taken as the clock rises
   // ----
   always @(posedge mdc_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 6'h00;
         rd_op <= 1'b0;
      end else begin
         sr <= {sr[62:0], line_in};
         cnt <= cnt + 6'h01;
         if (cnt == 6'h23) rd_op <= {sr[0], line_in} == 2'b10;
         if (cnt == 6'h3f) frame_out <= {sr[62:0], line_in};
      end
   end
   // Released bits toggle, so a stale level never passes for data
   always @(negedge mdc_in) begin
      if (rd_op && cnt >= 6'h2f) drv_out <= (cnt == 6'h2f) ? 1'b0 : rd_word_in[6'h3f - cnt];
      else drv_out <= ~drv_out;
   end
endmodule
`default_nettype wire

// *** mpf_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module mpf_monitor #(parameter MDC_HALF = 2) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Register port
   input wire logic [8:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   // Link and filter
   input wire logic mdc_out,
   input wire logic mdio_out,
   input wire logic mdio_oe_n_out,
   input wire logic chk_valid_in,
   input wire logic chk_done_out,
   input wire logic chk_accept_out
);
   localparam int FRAME = 128 * MDC_HALF;
   logic [9:0] busy_cnt;
   logic [3:0] cfg;
   logic rst_q;
   wire logic start = reg_wr_in && reg_addr_in == 9'h000 && busy_cnt == 10'h000;
   wire logic busy_now = busy_cnt != 10'h000;
   wire logic rx_en = cfg[0];
   default clocking cb @(posedge clk_sys_in); endclocking
   // Held one clock past release: the last reset edge still shows in sampled values
   default disable iff (rst_in || rst_q);
   // ----
   // Shadow of frame length, so busy is judged from the ports alone
   // ----
   always @(posedge clk_sys_in) begin
      rst_q <= rst_in;
      if (rst_in) begin
         busy_cnt <= 10'h000;
         cfg <= 4'h0;
      end else begin
         busy_cnt <= start ? 10'(FRAME) : busy_cnt - {9'h000, busy_now};
         if (reg_wr_in && reg_addr_in == 9'h008) cfg <= reg_wdata_in[3:0];
      end
   end
   sequence s_ctrl_rd;
      reg_rd_in && reg_addr_in == 9'h000;
   endsequence
   sequence s_mdc_high;
      mdc_out [*2] ##1 !mdc_out;
   endsequence
   property p_start_drive;
      start |=> (!mdio_oe_n_out && mdio_out && !mdc_out) ##2 mdc_out;
   endproperty
   a_start_drive: assert property (p_start_drive) else $error("bad frame start");
   property p_mdc_period;
      $rose(mdc_out) |-> s_mdc_high;
   endproperty
   a_mdc_period: assert property (p_mdc_period) else $error("bad mdc period");
   property p_mdio_hold;
      !$stable(mdio_out) && !mdio_oe_n_out && !$past(mdio_oe_n_out) |-> $fell(mdc_out);
   endproperty
   a_mdio_hold: assert property (p_mdio_hold) else $error("mdio moved off edge");
   property p_busy_read;
      s_ctrl_rd |=> reg_rdata_out[0] == $past(busy_now);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");
   property p_frame_end;
      busy_cnt == 10'h001 |=> mdio_oe_n_out && !mdc_out;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame end wrong");
   property p_reset_idle;
      $fell(rst_in) |-> reg_rdata_out == 32'h0000_0000 && mdio_oe_n_out && !chk_done_out;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
   property p_done_cause;
      chk_done_out == ($past(chk_valid_in) && $past(rx_en));
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done without cause");
   property p_accept_hold;
      !chk_done_out |-> $stable(chk_accept_out);
   endproperty
   a_accept_hold: assert property (p_accept_hold) else $error("accept moved");
   property p_accept_all;
      chk_valid_in && rx_en && cfg[3:2] == 2'h3 |=> chk_accept_out;
   endproperty
   a_accept_all: assert property (p_accept_all) else $error("accept-all refused");
endmodule
bind mpf_mac_mgmt_filter mpf_monitor #(.MDC_HALF(MDC_HALF)) u_mon (.clk_sys_in, .rst_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mdc_out, .mdio_out,
   .mdio_oe_n_out, .chk_valid_in, .chk_done_out, .chk_accept_out);
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   typedef struct packed {logic [3:0] c; logic [47:0] a; logic e;} mpf_row_t;
   localparam logic [47:0] A1 = 48'h0200_0000_0001, A2 = 48'h0200_0000_0002;
   localparam logic [47:0] A3 = 48'h0200_0000_0003, A4 = 48'h0a0b_0c0d_0e0f;
   localparam logic [47:0] M1 = 48'h0100_5e00_0001, M2 = 48'h0100_5e00_0002;
   logic clk_sys_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, chk_valid_in = 0;
   logic [8:0] reg_addr_in = 0, ix;
   logic [31:0] reg_wdata_in = 0, reg_rdata_out;
   logic [47:0] chk_addr_in = 0;
   logic [15:0] rd_word = 16'h5a3c;
   logic [63:0] frame;
   logic mdc_out, mdio_out, mdio_oe_n_out, chk_done_out, chk_accept_out, phy_drv;
   int fail_count = 0, total_checks = 0;
   mpf_row_t rows[13];
   wire mdio_line = mdio_oe_n_out ? phy_drv : mdio_out;
   mpf_mac_mgmt_filter uut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .mdc_out, .mdio_in(mdio_line), .mdio_out, .mdio_oe_n_out,
      .chk_valid_in, .chk_addr_in, .chk_done_out, .chk_accept_out);
   mpf_phy_model phy (.mdc_in(mdc_out), .rst_in, .line_in(mdio_line), .drv_out(phy_drv),
      .rd_word_in(rd_word), .frame_out(frame));
   always #50 clk_sys_in = ~clk_sys_in;
   // ----
   // Shared tasks
   // ----
   task automatic chk(string n, logic [63:0] s, logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [8:0] a, logic [31:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(logic [8:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      d = reg_rdata_out;
   endtask
   task automatic rchk(string n, logic [8:0] a, logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(n, 64'(v), 64'(e));
   endtask
   task automatic filt(logic [47:0] a, logic e, logic d);
      @(posedge clk_sys_in);
      chk_valid_in <= 1'b1;
      chk_addr_in <= a;
      @(posedge clk_sys_in);
      chk_valid_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("done", 64'(chk_done_out), 64'(d));
      if (d) chk("accept", 64'(chk_accept_out), 64'(e));
   endtask
   // Writes while busy must be dropped, so the final values prove the refusal
   task automatic mgmt(logic [31:0] c);
      logic [31:0] v;
      wr(9'h000, c);
      rchk("busy", 9'h000, c | 32'h1);
      wr(9'h004, 32'h0000_1111);
      wr(9'h000, 32'h0);
      v = 32'h1;
      for (int n = 0; n < 200 && v[0] !== 1'b0; n++) rd(9'h000, v);
      chk("idle", 64'(v), 64'(c));
   endtask
   function automatic logic [8:0] hidx(logic [47:0] a);
      logic [31:0] c;
      c = 32'hffff_ffff;
      for (int b = 0; b < 6; b++)
         for (int j = 0; j < 8; j++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8 * b + j]) ? 32'h04c1_1db7 : 32'h0);
      return c[31:23];
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      fail_count++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      rchk("ctrl", 9'h000, 32'h0);
      rchk("data", 9'h004, 32'h0);
      rchk("hole", 9'h020, 32'h0);
      wr(9'h008, 32'h1);
      filt(A3, 1'b1, 1'b1);
      wr(9'h008, 32'h0);
      filt(A3, 1'b1, 1'b0);
      $display("reset test done");
      // Tables loaded with reception off; entry 1 left invalid
      wr(9'h100, A1[31:0]);
      wr(9'h104, {16'hffff, A1[47:32]});
      wr(9'h108, A3[31:0]);
      wr(9'h10c, {16'h0, A3[47:32]});
      wr(9'h178, A4[31:0]);
      wr(9'h17c, {16'h8000, A4[47:32]});
      rchk("hi", 9'h104, 32'h8000_0200);
      wr(9'h010, A2[31:0]);
      wr(9'h014, {16'h0, A2[47:32]});
      ix = hidx(M1);
      wr({3'b110, ix[8:5], 2'b00}, 32'h1 << ix[4:0]);
      rows = '{{4'h1, A1, 1'b1}, {4'h1, A3, 1'b0}, {4'h1, A4, 1'b1}, {4'h3, A1, 1'b0},
         {4'h3, A3, 1'b1}, {4'h5, A2, 1'b1}, {4'h5, A1, 1'b0}, {4'h5, M1, 1'b1},
         {4'h5, M2, hidx(M2) == ix}, {4'h9, A2, hidx(A2) == ix}, {4'h9, M1, 1'b1},
         {4'hd, A3, 1'b1}, {4'h1, A1, 1'b1}};
      foreach (rows[i]) begin
         wr(9'h008, {28'h0, rows[i].c});
         filt(rows[i].a, rows[i].e, 1'b1);
      end
      rchk("stat", 9'h00c, {29'h0, hidx(A1) == ix, 2'b11});
      $display("filter table test done");
      wr(9'h004, 32'h0000_beef);
      mgmt(32'h0000_aa82);
      rchk("wdata", 9'h004, 32'h0000_beef);
      chk("wframe", frame | 64'h2_0000, {32'hffff_ffff, 4'h5, 5'h15, 5'h0a, 2'b10, 16'hbeef});
      $display("phy write test done");
      mgmt(32'h0000_0fc0);
      rchk("rdata", 9'h004, 32'h0000_5a3c);
      chk("rframe", frame | 64'h2_0000, {32'hffff_ffff, 4'h6, 5'h01, 5'h1f, 2'b10, 16'h5a3c});
      $display("phy read test done");
      wr(9'h000, 32'h0000_0fc0);
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      rchk("ctrl", 9'h000, 32'h0);
      chk("oe", 64'(mdio_oe_n_out), 64'h1);
      $display("abort test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
